// *** logic/adc_alarm_ref_dac_buffer.sv ***
// Chosen here: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "adc_alarm_map.svh"
module adc_alarm_ref_dac_buffer
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic irq,
	input wire logic convert_pin,
	input wire logic conv_done,
	input wire adc_alarm_pkg::sample_t conv_data,
	output logic conv_start,
	output logic [3:0] conv_channel,
	output logic bias_high,
	output logic global_alarm_out_n,
	output logic [3:0] gpio_alarm_out,
	output logic result_avail_out_n,
	output logic ref_int_enable,
	output logic ref_level_high,
	output logic [95:0] dac_code,
	output logic [7:0] dac_power_on
);
	import adc_alarm_pkg::*;

	seq_state_t state_reg, state_next;
	logic [3:0] cur_reg, cur_next, first_reg, last_reg, first_next;
	logic pass_reg, pass_next, cont_reg, ext_ref_reg, ref_hi_reg, ext_trig_reg;
	logic [3:0] alarm_flag_reg, alarm_flag_next, gpio_en_reg;
	logic result_avail_flag_reg, result_avail_flag_next;
	logic [7:0] pulse_cnt_reg, pulse_cnt_next;
	logic [1:0] irq_st_reg, irq_mask_reg, irq_st_next;
	logic pin_s1, pin_s2, pin_s3;
	sample_t v1_reg;
	sample_t tmp_reg [0:8];
	sample_t data_reg [0:8];
	sample_t lim_lo_reg [0:3];
	sample_t lim_hi_reg [0:3];
	sample_t latch [0:7];

	// Register port decode.
	wire hit_cfg = addr == `A_CFG;
	wire hit_ctrl = addr == `A_CTRL;
	wire hit_alarm = addr == `A_ALARM;
	wire hit_gpio = addr == `A_GPIOEN;
	wire hit_pwr = addr == `A_DACPWR;
	wire hit_ld = addr == `A_DACLD;
	wire hit_irqst = addr == `A_IRQST;
	wire hit_irqmsk = addr == `A_IRQMSK;
	wire in_lim = addr[7:4] == `A_LIM_TAG && addr[1:0] == 2'h0;
	wire in_adc = addr[7:6] == `A_ADC_TAG && addr[5:2] <= `TEMP_CHAN && addr[1:0] == 2'h0;
	wire in_dac = addr[7:5] == `A_DAC_TAG && addr[1:0] == 2'h0;
	wire [1:0] lim_idx = addr[3:2];
	wire [3:0] adc_idx = addr[5:2];
	wire [2:0] dac_idx = addr[4:2];

	// Trigger sources and mode.
	wire ext_rise = pin_s2 && !pin_s3;
	wire trig = ext_trig_reg ? ext_rise : (wr && hit_ctrl);
	wire cont_eff = cont_reg && !ext_trig_reg;
	assign first_next = (wr && hit_ctrl) ? wdata[`CTRL_FIRST] : first_reg;

	// Next values of written bits, so the pins they drive move with the register.
	wire [3:0] gpio_en_next = (wr && hit_gpio) ? wdata[3:0] : gpio_en_reg;
	wire ext_ref_next = (wr && hit_cfg) ? wdata[`CFG_EXTREF] : ext_ref_reg;
	wire ref_hi_next = (wr && hit_cfg) ? wdata[`CFG_REFHI] : ref_hi_reg;

	// Sequencer conditions and sample path.
	wire in_wait = state_reg == st_wait;
	wire temp_first = cur_reg == `TEMP_CHAN && !pass_reg;
	wire sample_done = in_wait && conv_done && !temp_first;
	wire at_last = cur_reg == last_reg;
	wire commit = sample_done && at_last;
	wire sample_t temp_diff = (v1_reg >= conv_data) ? v1_reg - conv_data : 12'h000;
	wire sample_t sample_val = (cur_reg == `TEMP_CHAN) ? temp_diff : conv_data;

	wire [3:0] mon_idx = cur_reg - first_reg;
	wire monitored = cur_reg >= first_reg && mon_idx < `MON_CHANS;
	wire out_rng = sample_val < lim_lo_reg[mon_idx[1:0]]
		|| sample_val > lim_hi_reg[mon_idx[1:0]];
	wire [3:0] alarm_set = (sample_done && monitored && out_rng)
		? (4'h1 << mon_idx[1:0]) : 4'h0;

	// Next conversion step.
	always_comb
	begin
		state_next = state_reg;
		cur_next = cur_reg;
		pass_next = pass_reg;
		if (trig)
		begin
			state_next = st_issue;
			cur_next = first_next;
			pass_next = 1'b0;
		end
		else
		begin
			case (state_reg)
				st_idle: state_next = st_idle;
				st_issue: state_next = st_wait;
				st_wait:
				begin
					if (conv_done && temp_first)
					begin
						pass_next = 1'b1;
						state_next = st_issue;
					end
					else if (conv_done && at_last)
					begin
						cur_next = first_reg;
						pass_next = 1'b0;
						state_next = cont_eff ? st_issue : st_idle;
					end
					else if (conv_done)
					begin
						cur_next = cur_reg + 4'h1;
						pass_next = 1'b0;
						state_next = st_issue;
					end
				end
				default: state_next = st_idle;
			endcase
		end
	end

	// Flags, pulse and interrupt next values; a set always wins over a clear.
	wire rd_adc = rd && in_adc;
	wire [1:0] irq_ev = {alarm_set != 4'h0, commit};
	wire [1:0] irq_clr = (wr && hit_irqst) ? wdata[1:0] : 2'h0;
	assign alarm_flag_next = (trig ? 4'h0 : alarm_flag_reg) | alarm_set;
	assign result_avail_flag_next = !cont_eff
		&& ((result_avail_flag_reg && !rd_adc && !trig) || commit);
	assign pulse_cnt_next = (commit && cont_eff) ? 8'(`AVAIL_PULSE_CYC)
		: (pulse_cnt_reg != 8'h00) ? pulse_cnt_reg - 8'h01 : 8'h00;
	assign irq_st_next = (irq_st_reg & ~irq_clr) | irq_ev;

	// External trigger pin synchroniser and edge stage.
	always_ff @(posedge mclk)
	begin
		if (reset)
			{pin_s1, pin_s2, pin_s3} <= 3'h0;
		else
			{pin_s1, pin_s2, pin_s3} <= {convert_pin, pin_s1, pin_s2};
	end

	// Sequencer state and converter request outputs.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state_reg <= st_idle;
			cur_reg <= 4'h0;
			pass_reg <= 1'b0;
			conv_start <= 1'b0;
			conv_channel <= 4'h0;
			bias_high <= 1'b0;
			v1_reg <= 12'h000;
		end
		else
		begin
			state_reg <= state_next;
			cur_reg <= cur_next;
			pass_reg <= pass_next;
			conv_start <= state_reg == st_issue;
			if (state_reg == st_issue)
				conv_channel <= cur_reg;
			if (state_reg == st_issue)
				bias_high <= temp_first;
			if (in_wait && conv_done && temp_first)
				v1_reg <= conv_data;
		end
	end

	// Result double buffer: holding stage per sample, all published at group end.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			for (int i = 0; i < `ADC_COUNT; i++)
			begin
				tmp_reg[i] <= 12'h000;
				data_reg[i] <= 12'h000;
			end
		end
		else
		begin
			for (int i = 0; i < `ADC_COUNT; i++)
			begin
				if (sample_done && cur_reg == 4'(i))
					tmp_reg[i] <= sample_val;
				if (commit)
					data_reg[i] <= (cur_reg == 4'(i)) ? sample_val : tmp_reg[i];
			end
		end
	end

	// Software-written configuration.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			first_reg <= 4'h0;
			last_reg <= 4'h0;
			cont_reg <= 1'b0;
			ext_ref_reg <= 1'b0;
			ref_hi_reg <= 1'b0;
			ext_trig_reg <= 1'b0;
			gpio_en_reg <= 4'h0;
			irq_mask_reg <= 2'h0;
			for (int i = 0; i < 4; i++)
			begin
				lim_lo_reg[i] <= 12'h000;
				lim_hi_reg[i] <= `LIM_HI_RST;
			end
		end
		else if (wr)
		begin
			first_reg <= first_next;
			if (hit_ctrl)
			begin
				last_reg <= wdata[`CTRL_LAST];
				cont_reg <= wdata[`CTRL_CONT];
			end
			if (hit_cfg)
			begin
				ext_ref_reg <= wdata[`CFG_EXTREF];
				ref_hi_reg <= wdata[`CFG_REFHI];
				ext_trig_reg <= wdata[`CFG_EXTTRIG];
			end
			if (hit_gpio)
				gpio_en_reg <= wdata[3:0];
			if (hit_irqmsk)
				irq_mask_reg <= wdata[1:0];
			if (in_lim)
			begin
				lim_lo_reg[lim_idx] <= wdata[`LIM_LO];
				lim_hi_reg[lim_idx] <= wdata[`LIM_HI];
			end
		end
	end

	// Status, pins and interrupt; pins follow the next flag values.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			alarm_flag_reg <= 4'h0;
			result_avail_flag_reg <= 1'b0;
			pulse_cnt_reg <= 8'h00;
			irq_st_reg <= 2'h0;
			irq <= 1'b0;
			global_alarm_out_n <= 1'b1;
			gpio_alarm_out <= 4'h0;
			result_avail_out_n <= 1'b1;
			ref_int_enable <= 1'b1;
			ref_level_high <= 1'b0;
		end
		else
		begin
			alarm_flag_reg <= alarm_flag_next;
			result_avail_flag_reg <= result_avail_flag_next;
			pulse_cnt_reg <= pulse_cnt_next;
			irq_st_reg <= irq_st_next;
			irq <= (irq_st_next & irq_mask_reg) != 2'h0;
			global_alarm_out_n <= alarm_flag_next == 4'h0;
			gpio_alarm_out <= alarm_flag_next & gpio_en_next;
			result_avail_out_n <= !(result_avail_flag_next || pulse_cnt_next != 8'h00);
			ref_int_enable <= !ext_ref_next;
			ref_level_high <= ref_hi_next && !ext_ref_next;
		end
	end

	// DAC channels.
	wire [7:0] dac_load = (wr && hit_ld) ? wdata[7:0] : 8'h00;
	for (genvar g = 0; g < `DAC_COUNT; g++)
	begin : g_dac
		dac_channel u_dac
		(
			.mclk(mclk),
			.reset(reset),
			.data_wr(wr && in_dac && dac_idx == 3'(g)),
			.wdata(wdata[11:0]),
			.load(dac_load[g]),
			.power_wr(wr && hit_pwr),
			.power_in(wdata[g]),
			.latch_out(latch[g]),
			.dac_power_on(dac_power_on[g])
		);
		assign dac_code[g*12 +: 12] = latch[g];
	end

	// Read multiplexer.
	wire [31:0] cfg_word = {28'h0, result_avail_flag_reg, ext_trig_reg, ref_hi_reg, ext_ref_reg};
	wire [31:0] ctrl_word = {23'h0, cont_reg, last_reg, first_reg};
	wire [31:0] lim_word = {4'h0, lim_hi_reg[lim_idx], 4'h0, lim_lo_reg[lim_idx]};
	wire [31:0] rd_mux = hit_cfg ? cfg_word
		: hit_ctrl ? ctrl_word
		: hit_alarm ? {28'h0, alarm_flag_reg}
		: hit_gpio ? {28'h0, gpio_en_reg}
		: hit_pwr ? {24'h0, dac_power_on}
		: hit_irqst ? {30'h0, irq_st_reg}
		: hit_irqmsk ? {30'h0, irq_mask_reg}
		: in_lim ? lim_word
		: in_adc ? {20'h0, data_reg[adc_idx]}
		: in_dac ? {20'h0, latch[dac_idx]}
		: 32'h0;

	// Read data stand one cycle after the strobe, zero otherwise.
	always_ff @(posedge mclk)
	begin
		if (reset)
			rdata <= 32'h0;
		else
			rdata <= rd ? rd_mux : 32'h0;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_temp_first;
		state_reg == st_issue && temp_first;
	endsequence
	sequence s_temp_second;
		state_reg == st_issue && cur_reg == `TEMP_CHAN && pass_reg;
	endsequence

	property p_alarm_set;
		sample_done && monitored && out_rng && !trig |=> alarm_flag_reg != 4'h0;
	endproperty
	a_alarm_set: assert property (p_alarm_set) else $error("Alarm flag not set.");
	property p_global;
		alarm_flag_reg != 4'h0 |-> !global_alarm_out_n;
	endproperty
	a_global: assert property (p_global) else $error("Global alarm not low.");
	property p_gpio;
		gpio_alarm_out == (alarm_flag_reg & gpio_en_reg);
	endproperty
	a_gpio: assert property (p_gpio) else $error("Alarm pin mismatch.");
	property p_trig_clear;
		trig && alarm_set == 4'h0 |=> global_alarm_out_n && alarm_flag_reg == 4'h0;
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("Trigger left alarms.");
	property p_ref;
		ref_int_enable == !ext_ref_reg && (!ext_ref_reg || !ref_level_high);
	endproperty
	a_ref: assert property (p_ref) else $error("Reference outputs wrong.");
	property p_read_clear;
		rd_adc && !commit |=> !result_avail_flag_reg;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("Read did not clear flag.");
	property p_cont_flag;
		cont_eff |=> !result_avail_flag_reg;
	endproperty
	a_cont_flag: assert property (p_cont_flag) else $error("Flag set in continuous mode.");
	property p_temp_hi;
		s_temp_first |=> bias_high && conv_start;
	endproperty
	a_temp_hi: assert property (p_temp_hi) else $error("First pass not high bias.");
	property p_temp_lo;
		s_temp_second |=> !bias_high && conv_start;
	endproperty
	a_temp_lo: assert property (p_temp_lo) else $error("Second pass not low bias.");
	property p_done;
		commit && !cont_eff |=> result_avail_flag_reg && !result_avail_out_n;
	endproperty
	a_done: assert property (p_done) else $error("Single pass done not flagged.");
	property p_pulse;
		commit && cont_eff && !trig |=> !result_avail_out_n [*8];
	endproperty
	a_pulse: assert property (p_pulse) else $error("Availability pulse too short.");
endmodule : adc_alarm_ref_dac_buffer
`default_nettype wire

// *** inc/adc_alarm_map.svh ***
`ifndef ADC_ALARM_MAP_SVH
`define ADC_ALARM_MAP_SVH
// Register byte addresses on the 8-bit register port.
`define A_CFG 8'h00
`define A_CTRL 8'h04
`define A_ALARM 8'h08
`define A_GPIOEN 8'h0c
`define A_DACPWR 8'h10
`define A_DACLD 8'h14
`define A_IRQST 8'h18
`define A_IRQMSK 8'h1c
// Windows: limits 0x20-0x2c, converter results 0x40-0x60, DAC words 0x80-0x9c.
`define A_LIM_TAG 4'h2
`define A_ADC_TAG 2'h1
`define A_DAC_TAG 3'h4
// Configuration register bits.
`define CFG_EXTREF 0
`define CFG_REFHI 1
`define CFG_EXTTRIG 2
`define CFG_AVAIL 3
// Conversion control register fields.
`define CTRL_FIRST 3:0
`define CTRL_LAST 7:4
`define CTRL_CONT 8
// Limit register fields.
`define LIM_LO 11:0
`define LIM_HI 27:16
`define LIM_HI_RST 12'hfff
// Interrupt status bits.
`define IRQ_DONE 0
`define IRQ_ALARM 1
// Channel facts.
`define TEMP_CHAN 4'h8
`define MON_CHANS 4'h4
`define DAC_COUNT 8
`define ADC_COUNT 9
// Low pulse on the availability pin in continuous mode.
`define AVAIL_PULSE_NS 2000
`define MCLK_MHZ 100
`define AVAIL_PULSE_CYC ((`AVAIL_PULSE_NS * `MCLK_MHZ) / 1000)
`endif

// *** inc/adc_alarm_pkg.sv ***
`default_nettype none
package adc_alarm_pkg;
	typedef logic [11:0] sample_t;
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_issue = 3'b010,
		st_wait = 3'b100
	} seq_state_t;
endpackage : adc_alarm_pkg
`default_nettype wire

// *** logic/dac_channel.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "adc_alarm_map.svh"
module dac_channel
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic data_wr,
	input wire adc_alarm_pkg::sample_t wdata,
	input wire logic load,
	input wire logic power_wr,
	input wire logic power_in,
	output adc_alarm_pkg::sample_t latch_out,
	output logic dac_power_on
);
	import adc_alarm_pkg::*;
	sample_t data_reg;

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			data_reg <= 12'h000;
			latch_out <= 12'h000;
			dac_power_on <= 1'b0;
		end
		else
		begin
			if (data_wr)
				data_reg <= wdata;
			if (load)
				latch_out <= data_reg; // Only a load moves the output code.
			if (power_wr)
				dac_power_on <= power_in;
		end
	end

	property p_latch_hold;
		@(posedge mclk) disable iff (reset)
		!load |=> $stable(latch_out);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("DAC latch moved without load.");
endmodule : dac_channel
`default_nettype wire

// *** testbench/conv_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module conv_model
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic conv_start,
	input wire logic [3:0] conv_channel,
	input wire logic bias_high,
	input wire logic slow,
	output logic conv_done,
	output adc_alarm_pkg::sample_t conv_data
);
	import adc_alarm_pkg::*;
	logic busy_reg;
	logic [6:0] wait_reg;
	sample_t value;
	// Temperature passes give a fixed diode pair, other channels show their number.
	// bias selects pass
	assign value = (conv_channel == 4'h8) ? (bias_high ? 12'h9a0 : 12'h120) :
		{conv_channel, 8'h40};
	// One answer per request, after a short or long conversion time.
	// The data lines toggle while not valid so a stale value is never read.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			busy_reg <= 1'b0;
			wait_reg <= 7'h00;
			conv_done <= 1'b0;
			conv_data <= 12'h000;
		end
		else
		begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
			if (busy_reg && wait_reg == 7'h00)
			begin
				busy_reg <= 1'b0;
				conv_done <= 1'b1;
				conv_data <= value;
			end
			else if (busy_reg)
				wait_reg <= wait_reg - 7'h01;
			else if (conv_start)
			begin
				busy_reg <= 1'b1;
				wait_reg <= slow ? 7'h64 : 7'h03;
			end
		end
	end
endmodule : conv_model
`default_nettype wire

// *** testbench/adc_alarm_ref_dac_buffer_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "adc_alarm_map.svh"
module adc_alarm_ref_dac_buffer_test;
	import adc_alarm_pkg::*;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic slow = 1'b0;
	logic convert_pin = 1'b0;
	logic [31:0] rdata;
	logic irq, conv_done, conv_start, bias_high;
	logic global_alarm_out_n, result_avail_out_n, ref_int_enable, ref_level_high;
	sample_t conv_data;
	logic [3:0] conv_channel, gpio_alarm_out;
	logic [95:0] dac_code;
	logic [7:0] dac_power_on;
	logic [1:0] bias_seq = 2'h0;
	logic [31:0] v;
	int n_fail = 0;
	int total_checks = 0;
	int n;

	adc_alarm_ref_dac_buffer adc_alarm_ref_dac_buffer_i (.mclk(mclk), .reset(reset),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
		.convert_pin(convert_pin), .conv_done(conv_done), .conv_data(conv_data),
		.conv_start(conv_start), .conv_channel(conv_channel), .bias_high(bias_high),
		.global_alarm_out_n(global_alarm_out_n), .gpio_alarm_out(gpio_alarm_out),
		.result_avail_out_n(result_avail_out_n), .ref_int_enable(ref_int_enable),
		.ref_level_high(ref_level_high), .dac_code(dac_code), .dac_power_on(dac_power_on));

	conv_model conv_model_i (.mclk(mclk), .reset(reset), .conv_start(conv_start),
		.conv_channel(conv_channel), .bias_high(bias_high), .slow(slow),
		.conv_done(conv_done), .conv_data(conv_data));

	// Clock of 10 ns period.
	always #5 mclk = ~mclk;

	// Records the bias level of each temperature pass.
	always @(posedge mclk)
		if (conv_start === 1'b1 && conv_channel === `TEMP_CHAN)
			bias_seq <= {bias_seq[0], bias_high};

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wreg

	task rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		v = rdata;
		check(v, e);
	endtask : rchk

	task cycles(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : cycles

	// Waits a bounded time for the availability pin to go low.
	task wait_avail;
		n = 0;
		while (result_avail_out_n !== 1'b0 && n < 2000)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		check({31'h0, n < 2000}, 32'h1);
	endtask : wait_avail

	task final_report;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	// Cuts a hang short well beyond the expected run time.
	initial
	begin
		#500000;
		n_fail++;
		final_report();
	end

	// Main sequence.
	initial
	begin
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		rchk(`A_CFG, 32'h0);
		check({31'h0, ref_int_enable}, 32'h1);
		check({31'h0, ref_level_high}, 32'h0);
		check({24'h0, dac_power_on}, 32'h0);
		check(dac_code[31:0], 32'h0);
		check({30'h0, global_alarm_out_n, result_avail_out_n}, 32'h3);
		wreg(`A_CFG, 32'h2);
		cycles(2);
		check({30'h0, ref_int_enable, ref_level_high}, 32'h3);
		wreg(`A_CFG, 32'h3);
		cycles(2);
		check({30'h0, ref_int_enable, ref_level_high}, 32'h0);
		rchk(`A_CFG, 32'h3);
		// The level bit goes back low, as a low supply demands.
		wreg(`A_CFG, 32'h0);
		wreg(8'h8c, 32'habc);
		wreg(`A_DACPWR, 32'h08);
		rchk(8'h8c, 32'h0);
		check({20'h0, dac_code[47:36]}, 32'h0);
		check({24'h0, dac_power_on}, 32'h08);
		wreg(`A_DACLD, 32'h08);
		cycles(2);
		check({20'h0, dac_code[47:36]}, 32'habc);
		rchk(8'h8c, 32'habc);
		rchk(8'h88, 32'h0);
		// Group 1 to 5; channels 1 and 4 exceed a tight upper limit.
		wreg(8'h20, 32'h01000000);
		wreg(8'h2c, 32'h01000000);
		wreg(`A_GPIOEN, 32'h1);
		wreg(`A_IRQMSK, 32'h3);
		wreg(`A_CTRL, 32'h51);
		wait_avail();
		cycles(2);
		rchk(`A_ALARM, 32'h9);
		check({31'h0, global_alarm_out_n}, 32'h0);
		check({28'h0, gpio_alarm_out}, 32'h1);
		rchk(`A_CFG, 32'h8);
		check({31'h0, irq}, 32'h1);
		rchk(`A_IRQST, 32'h3);
		wreg(`A_IRQMSK, 32'h0);
		cycles(2);
		check({31'h0, irq}, 32'h0);
		wreg(`A_IRQMSK, 32'h3);
		wreg(`A_IRQST, 32'h3);
		cycles(2);
		check({31'h0, irq}, 32'h0);
		rchk(`A_IRQST, 32'h0);
		rchk(8'h44, 32'h140);
		cycles(1);
		check({31'h0, result_avail_out_n}, 32'h1);
		rchk(`A_CFG, 32'h0);
		rchk(8'hfc, 32'h0);
		// Retrigger with the temperature channel and a slow converter.
		wreg(8'h20, 32'h0fff0000);
		wreg(8'h2c, 32'h0fff0000);
		slow <= 1'b1;
		wreg(`A_CTRL, 32'h87);
		cycles(1);
		rchk(`A_ALARM, 32'h0);
		check({31'h0, global_alarm_out_n}, 32'h1);
		wait_avail();
		cycles(2);
		check({30'h0, bias_seq}, 32'h2);
		rchk(8'h60, 32'h880);
		// Continuous group of channels 7 and 8.
		wreg(`A_CTRL, 32'h187);
		wait_avail();
		n = 0;
		while (result_avail_out_n === 1'b0 && n < 1000)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		check(n, `AVAIL_PULSE_CYC);
		rchk(`A_CFG, 32'h0);
		// Enabling the pin trigger stops the repeat after the running group.
		wreg(`A_CFG, 32'h4);
		wait_avail();
		rchk(`A_CFG, 32'hc);
		rchk(8'h60, 32'h880);
		// A rising edge on the trigger pin starts one more pass of the group.
		convert_pin <= 1'b1;
		wait_avail();
		rchk(8'h60, 32'h880);
		convert_pin <= 1'b0;
		wreg(`A_CFG, 32'h0);
		slow <= 1'b0;
		wreg(`A_CTRL, 32'h0);
		wait_avail();
		rchk(8'h40, 32'h040);
		final_report();
	end
endmodule : adc_alarm_ref_dac_buffer_test
`default_nettype wire
